// [inc/tap_pkg.sv]
// shared constants, register map and state codes of the trim and angle path
package tap_pkg;

	// data widths
	localparam int unsigned SAMPLE_W = 16;
	localparam int unsigned TEMP_W = 12;
	localparam int unsigned GAIN_W = 14;
	localparam int unsigned GLIN_W = 11;
	localparam int unsigned GQUAD_W = 10;
	localparam int unsigned OFFS_W = 14;
	localparam int unsigned ODRIFT_W = 12;
	localparam int unsigned HYST_W = 10;
	localparam int unsigned PHASE_W = 16;
	localparam int unsigned ANG_W = 16;
	localparam int unsigned ANGOFF_W = 15;
	localparam int unsigned THR_W = 8;
	localparam int unsigned CH_N = 2;

	// global register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ANG_OFFS = 8'h04;
	localparam logic [7:0] OFF_THRESH = 8'h08;
	localparam logic [7:0] OFF_ANGLE = 8'h0C;
	localparam logic [7:0] OFF_PHASE = 8'h10;
	// per-channel register block: base + channel * stride + offset
	localparam logic [7:0] OFF_CH_BASE = 8'h20;
	localparam logic [7:0] OFF_CH_STRIDE = 8'h20;
	localparam logic [7:0] OFF_GAIN = 8'h00;
	localparam logic [7:0] OFF_GDRIFT_LIN = 8'h04;
	localparam logic [7:0] OFF_GDRIFT_QUAD = 8'h08;
	localparam logic [7:0] OFF_OFFSET = 8'h0C;
	localparam logic [7:0] OFF_ODRIFT = 8'h10;
	localparam logic [7:0] OFF_HYST = 8'h14;
	localparam logic [7:0] OFF_READBACK = 8'h18;

	// field positions
	localparam int unsigned CTRL_INV_LSB = 0;
	localparam int unsigned CTRL_BYPASS = 2;
	localparam int unsigned CTRL_ORDER = 3;
	localparam int unsigned CTRL_THR_EN = 4;
	localparam int unsigned CTRL_W = 5;
	localparam int unsigned HIGH_TEMP_LSB = 16;
	localparam int unsigned THR_HIGH_LSB = 8;
	localparam int unsigned ANGLE_SAT_BIT = 16;

	// reset values
	localparam logic [GAIN_W-1:0] GAIN_RST = 14'h0800;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

	// fixed point scaling, temperature code is 1/8 K with 25 C at code 2048
	localparam logic [TEMP_W-1:0] TEMP_REF = 12'h800;
	localparam int unsigned GAIN_FRAC = 11;
	localparam int unsigned PHASE_FRAC = 15;
	localparam int unsigned FACTOR_FRAC = 31;
	localparam int unsigned GLIN_LOW_SH = 11;
	localparam int unsigned GLIN_HIGH_SH = 10;
	localparam int unsigned GQUAD_LOW_SH = 2;
	localparam int unsigned GQUAD_HIGH_SH = 0;
	localparam int unsigned OFFS_STEP_SH = 2;
	localparam int unsigned ODRIFT_LOW_SH = 7;
	localparam int unsigned ODRIFT_HIGH_SH = 6;
	localparam int unsigned ANGOFF_SH = 1;
	localparam logic [ANG_W-1:0] BYPASS_BIAS = 16'h8000;
	localparam logic signed [63:0] SAT_MAX = 64'sh7FFF;
	localparam logic signed [63:0] SAT_MIN = -64'sh8000;

	// arctangent, 65536 codes per turn
	localparam int unsigned CORDIC_ITER = 16;
	localparam int unsigned CORDIC_W = 19;
	localparam logic [ANG_W-1:0] HALF_TURN = 16'h8000;
	localparam logic [ANG_W-1:0] CORDIC_ATAN [16] = '{
		16'h2000, 16'h12E4, 16'h09FB, 16'h0511, 16'h028B, 16'h0146,
		16'h00A3, 16'h0051, 16'h0029, 16'h0014, 16'h000A, 16'h0005,
		16'h0003, 16'h0001, 16'h0001, 16'h0000};

	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_TRIM = 6'b000010,
		S_HYST = 6'b000100,
		S_ATAN = 6'b001000,
		S_WAIT = 6'b010000,
		S_OUT = 6'b100000
	} tap_path_e;

	typedef enum logic [1:0] {
		C_IDLE = 2'b01,
		C_RUN = 2'b10
	} tap_cordic_e;

	localparam logic [1:0] DIR_NONE = 2'b00;
	localparam logic [1:0] DIR_UP = 2'b01;
	localparam logic [1:0] DIR_DOWN = 2'b10;

endpackage

// [logic/tap_cordic.sv]
// iterative vectoring arctangent, one iteration per enabled clock
module tap_cordic
	import tap_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// request
	input wire logic start_i,
	input wire logic signed [SAMPLE_W-1:0] sin_i,
	input wire logic signed [SAMPLE_W-1:0] cos_i,
	// result
	output logic [ANG_W-1:0] angle_o,
	output logic done_o
);

	tap_cordic_e state_q, state_d;
	logic signed [CORDIC_W-1:0] x_q, x_d, y_q, y_d;
	logic [ANG_W-1:0] z_q, z_d, angle_d;
	logic [3:0] iter_q, iter_d;
	logic done_d;

	always_comb begin
		state_d = state_q;
		x_d = x_q;
		y_d = y_q;
		z_d = z_q;
		iter_d = iter_q;
		angle_d = angle_o;
		done_d = 1'b0;
		unique case (state_q)
			C_IDLE: begin
				if (start_i) begin
					// left half plane: turn by half a turn so the loop converges
					if (cos_i < 0) begin
						x_d = -CORDIC_W'(cos_i);
						y_d = -CORDIC_W'(sin_i);
						z_d = HALF_TURN;
					end else begin
						x_d = CORDIC_W'(cos_i);
						y_d = CORDIC_W'(sin_i);
						z_d = '0;
					end
					iter_d = '0;
					state_d = C_RUN;
				end
			end
			C_RUN: begin
				if (y_q >= 0) begin
					x_d = x_q + (y_q >>> iter_q);
					y_d = y_q - (x_q >>> iter_q);
					z_d = z_q + CORDIC_ATAN[iter_q];
				end else begin
					x_d = x_q - (y_q >>> iter_q);
					y_d = y_q + (x_q >>> iter_q);
					z_d = z_q - CORDIC_ATAN[iter_q];
				end
				iter_d = iter_q + 4'h1;
				if (iter_q == 4'(CORDIC_ITER - 1)) begin
					angle_d = z_d;
					done_d = 1'b1;
					state_d = C_IDLE;
				end
			end
			default: state_d = C_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= C_IDLE;
			x_q <= '0;
			y_q <= '0;
			z_q <= '0;
			iter_q <= '0;
			angle_o <= '0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			state_q <= state_d;
			x_q <= x_d;
			y_q <= y_d;
			z_q <= z_d;
			iter_q <= iter_d;
			angle_o <= angle_d;
			done_o <= done_d;
		end
	end

endmodule

// [logic/tap_trim_path.sv]
// two-channel customer trim, hysteresis, arctangent and zero-angle offset
module tap_trim_path
	import tap_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// factory-corrected samples and temperature
	input wire logic sample_valid_i,
	input wire logic signed [SAMPLE_W-1:0] sample_a_i,
	input wire logic signed [SAMPLE_W-1:0] sample_b_i,
	input wire logic [TEMP_W-1:0] temp_i,
	output logic busy_o,
	// angle towards the gain stage
	output logic angle_valid_o,
	output logic [ANG_W-1:0] angle_o,
	output logic sat_flag_o
);

	tap_path_e state_q, state_d;
	logic [CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [ANGOFF_W-1:0] ang_offs_q, ang_offs_d;
	logic [THR_W-1:0] thr_low_q, thr_low_d, thr_high_q, thr_high_d;
	logic signed [PHASE_W-1:0] phase_q, phase_d;
	logic signed [SAMPLE_W-1:0] samp_q [CH_N];
	logic signed [SAMPLE_W-1:0] samp_d [CH_N];
	logic signed [SAMPLE_W-1:0] hyst_out [CH_N];
	logic signed [TEMP_W:0] dt_q, dt_d;
	logic [ANG_W-1:0] angle0_q, angle0_d, angle_d, cordic_angle, ang_sum;
	logic angle_valid_d, sat_d, busy_d, cordic_start, cordic_done;
	logic signed [SAMPLE_W-1:0] sin_sel, cos_sel;
	logic signed [63:0] ortho;
	logic [31:0] ch_rdata [CH_N];
	logic [CH_N-1:0] ch_hit;
	logic wr_en, glob_hit;
	logic [31:0] prdata_d, glob_rdata;
	logic pready_d, pslverr_d;

	// apb: setup cycle decodes, access cycle answers with no wait state
	assign wr_en = psel_i & penable_i & pready_o & pwrite_i;

	always_comb begin
		glob_hit = 1'b1;
		glob_rdata = '0;
		unique case (paddr_i)
			OFF_CTRL: glob_rdata = 32'(ctrl_q);
			OFF_ANG_OFFS: glob_rdata = 32'(ang_offs_q);
			OFF_THRESH: glob_rdata = 32'({thr_high_q, thr_low_q});
			OFF_ANGLE: glob_rdata = 32'({sat_flag_o, angle_o});
			OFF_PHASE: glob_rdata = 32'(phase_q);
			default: glob_hit = 1'b0;
		endcase
	end

	always_comb begin
		prdata_d = prdata_o;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		if (psel_i && !penable_i) begin
			pready_d = 1'b1;
			pslverr_d = !(glob_hit || (|ch_hit));
			prdata_d = glob_rdata | ch_rdata[0] | ch_rdata[1];
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prdata_o <= '0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else if (ce_i) begin
			prdata_o <= prdata_d;
			pready_o <= pready_d;
			pslverr_o <= pslverr_d;
		end
	end

	// global registers
	always_comb begin
		ctrl_d = ctrl_q;
		ang_offs_d = ang_offs_q;
		thr_low_d = thr_low_q;
		thr_high_d = thr_high_q;
		phase_d = phase_q;
		if (wr_en) begin
			unique case (paddr_i)
				OFF_CTRL: ctrl_d = pwdata_i[CTRL_W-1:0];
				OFF_ANG_OFFS: ang_offs_d = pwdata_i[ANGOFF_W-1:0];
				OFF_THRESH: begin
					thr_low_d = pwdata_i[THR_W-1:0];
					thr_high_d = pwdata_i[THR_HIGH_LSB +: THR_W];
				end
				OFF_PHASE: phase_d = pwdata_i[PHASE_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_q <= CTRL_RST;
			ang_offs_q <= '0;
			thr_low_q <= '0;
			thr_high_q <= '0;
			phase_q <= '0;
		end else if (ce_i) begin
			ctrl_q <= ctrl_d;
			ang_offs_q <= ang_offs_d;
			thr_low_q <= thr_low_d;
			thr_high_q <= thr_high_d;
			phase_q <= phase_d;
		end
	end

	// capture of a sample pair; the orthogonality term uses the raw first axis
	always_comb begin
		ortho = 64'(sample_b_i)
			+ ((64'(phase_q) * 64'(sample_a_i)) >>> PHASE_FRAC);
		samp_d = samp_q;
		dt_d = dt_q;
		if (state_q == S_IDLE && sample_valid_i) begin
			samp_d[0] = sample_a_i;
			if (ortho > SAT_MAX)
				samp_d[1] = 16'sh7FFF;
			else if (ortho < SAT_MIN)
				samp_d[1] = -16'sh8000;
			else
				samp_d[1] = ortho[SAMPLE_W-1:0];
			dt_d = $signed({1'b0, temp_i}) - $signed({1'b0, TEMP_REF});
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			samp_q <= '{default: '0};
			dt_q <= '0;
		end else if (ce_i) begin
			samp_q <= samp_d;
			dt_q <= dt_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < CH_N; g++) begin : g_ch
			localparam logic [7:0] BASE = OFF_CH_BASE + 8'(g) * OFF_CH_STRIDE;
			logic [GAIN_W-1:0] gain_q, gain_d;
			logic signed [GLIN_W-1:0] glin_lo_q, glin_lo_d, glin_hi_q, glin_hi_d;
			logic signed [GQUAD_W-1:0] gq_lo_q, gq_lo_d, gq_hi_q, gq_hi_d;
			logic signed [OFFS_W-1:0] offs_q, offs_d;
			logic signed [ODRIFT_W-1:0] od_lo_q, od_lo_d, od_hi_q, od_hi_d;
			logic [HYST_W-1:0] hyst_q, hyst_d;
			logic signed [SAMPLE_W-1:0] trim_q, trim_d, out_q, out_d;
			logic [1:0] dir_q, dir_d;
			logic seen_q, seen_d;
			logic signed [16:0] inv;
			logic signed [63:0] dt, dt2, g1, fac, scaled, acc;
			logic signed [17:0] lo, hi;
			logic cold;

			// channel registers
			always_comb begin
				gain_d = gain_q;
				glin_lo_d = glin_lo_q;
				glin_hi_d = glin_hi_q;
				gq_lo_d = gq_lo_q;
				gq_hi_d = gq_hi_q;
				offs_d = offs_q;
				od_lo_d = od_lo_q;
				od_hi_d = od_hi_q;
				hyst_d = hyst_q;
				ch_hit[g] = 1'b1;
				ch_rdata[g] = '0;
				unique case (paddr_i)
					BASE + OFF_GAIN: ch_rdata[g] = 32'(gain_q);
					BASE + OFF_GDRIFT_LIN: ch_rdata[g] = {5'h00,
						glin_hi_q, 5'h00, glin_lo_q};
					BASE + OFF_GDRIFT_QUAD: ch_rdata[g] = {6'h00,
						gq_hi_q, 6'h00, gq_lo_q};
					BASE + OFF_OFFSET: ch_rdata[g] = 32'(unsigned'(offs_q));
					BASE + OFF_ODRIFT: ch_rdata[g] = {4'h0,
						od_hi_q, 4'h0, od_lo_q};
					BASE + OFF_HYST: ch_rdata[g] = 32'(hyst_q);
					BASE + OFF_READBACK: ch_rdata[g] = 32'(unsigned'(out_q));
					default: ch_hit[g] = 1'b0;
				endcase
				if (wr_en) begin
					unique case (paddr_i)
						BASE + OFF_GAIN: gain_d = pwdata_i[GAIN_W-1:0];
						BASE + OFF_GDRIFT_LIN: begin
							glin_lo_d = pwdata_i[GLIN_W-1:0];
							glin_hi_d = pwdata_i[HIGH_TEMP_LSB +: GLIN_W];
						end
						BASE + OFF_GDRIFT_QUAD: begin
							gq_lo_d = pwdata_i[GQUAD_W-1:0];
							gq_hi_d = pwdata_i[HIGH_TEMP_LSB +: GQUAD_W];
						end
						BASE + OFF_OFFSET: offs_d = pwdata_i[OFFS_W-1:0];
						BASE + OFF_ODRIFT: begin
							od_lo_d = pwdata_i[ODRIFT_W-1:0];
							od_hi_d = pwdata_i[HIGH_TEMP_LSB +: ODRIFT_W];
						end
						BASE + OFF_HYST: hyst_d = pwdata_i[HYST_W-1:0];
						default: ;
					endcase
				end
			end

			always_ff @(posedge clock_i or negedge rstn_i) begin
				if (!rstn_i) begin
					gain_q <= GAIN_RST;
					glin_lo_q <= '0;
					glin_hi_q <= '0;
					gq_lo_q <= '0;
					gq_hi_q <= '0;
					offs_q <= '0;
					od_lo_q <= '0;
					od_hi_q <= '0;
					hyst_q <= '0;
				end else if (ce_i) begin
					gain_q <= gain_d;
					glin_lo_q <= glin_lo_d;
					glin_hi_q <= glin_hi_d;
					gq_lo_q <= gq_lo_d;
					gq_hi_q <= gq_hi_d;
					offs_q <= offs_d;
					od_lo_q <= od_lo_d;
					od_hi_q <= od_hi_d;
					hyst_q <= hyst_d;
				end
			end

			// trim arithmetic, gain drift terms scaled to a common 2^-31 factor, offset terms added after scaling
			always_comb begin
				cold = dt_q[TEMP_W];
				dt = 64'(dt_q);
				dt2 = dt * dt;
				inv = ctrl_q[CTRL_INV_LSB + g] ? -17'(samp_q[g]) : 17'(samp_q[g]);
				g1 = (64'(inv) * 64'($signed({1'b0, gain_q})))
					>>> GAIN_FRAC;
				if (cold)
					fac = (64'sd1 <<< FACTOR_FRAC)
						+ ((64'(glin_lo_q) * dt) <<< GLIN_LOW_SH)
						+ ((64'(gq_lo_q) * dt2) <<< GQUAD_LOW_SH);
				else
					fac = (64'sd1 <<< FACTOR_FRAC)
						+ ((64'(glin_hi_q) * dt) <<< GLIN_HIGH_SH)
						+ ((64'(gq_hi_q) * dt2) <<< GQUAD_HIGH_SH);
				scaled = (g1 * fac) >>> FACTOR_FRAC;
				acc = scaled + (64'(offs_q) <<< OFFS_STEP_SH);
				if (cold)
					acc = acc + ((64'(od_lo_q) * dt) >>> ODRIFT_LOW_SH);
				else
					acc = acc + ((64'(od_hi_q) * dt) >>> ODRIFT_HIGH_SH);
				trim_d = trim_q;
				if (state_q == S_TRIM) begin
					if (acc > SAT_MAX)
						trim_d = 16'sh7FFF;
					else if (acc < SAT_MIN)
						trim_d = -16'sh8000;
					else
						trim_d = acc[SAMPLE_W-1:0];
				end
			end

			// hysteresis: head sits on the input, output holds inside window
			always_comb begin
				lo = 18'(out_q) - 18'(hyst_q);
				hi = 18'(out_q) + 18'(hyst_q);
				out_d = out_q;
				dir_d = dir_q;
				seen_d = seen_q;
				if (state_q == S_HYST) begin
					seen_d = 1'b1;
					if (hyst_q == '0 || !seen_q) begin
						out_d = trim_q;
					end else if (dir_q == DIR_NONE) begin
						if (trim_q != out_q) begin
							dir_d = (trim_q > out_q) ? DIR_UP : DIR_DOWN;
							out_d = trim_q;
						end
					end else if (dir_q == DIR_UP) begin
						if (trim_q > out_q)
							out_d = trim_q;
						else if (18'(trim_q) < lo) begin
							dir_d = DIR_DOWN;
							out_d = trim_q;
						end
					end else begin
						if (trim_q < out_q)
							out_d = trim_q;
						else if (18'(trim_q) > hi) begin
							dir_d = DIR_UP;
							out_d = trim_q;
						end
					end
				end
			end

			always_ff @(posedge clock_i or negedge rstn_i) begin
				if (!rstn_i) begin
					trim_q <= '0;
					out_q <= '0;
					dir_q <= DIR_NONE;
					seen_q <= 1'b0;
				end else if (ce_i) begin
					trim_q <= trim_d;
					out_q <= out_d;
					dir_q <= dir_d;
					seen_q <= seen_d;
				end
			end

			assign hyst_out[g] = out_q;
		end
	endgenerate

	// angle selection and sequencing
	assign sin_sel = ctrl_q[CTRL_ORDER] ? hyst_out[1] : hyst_out[0];
	assign cos_sel = ctrl_q[CTRL_ORDER] ? hyst_out[0] : hyst_out[1];
	assign cordic_start = (state_q == S_ATAN) && !ctrl_q[CTRL_BYPASS];
	assign ang_sum = angle0_q + {ang_offs_q, 1'b0};

	tap_cordic u_cordic (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.start_i(cordic_start),
		.sin_i(sin_sel),
		.cos_i(cos_sel),
		.angle_o(cordic_angle),
		.done_o(cordic_done)
	);

	always_comb begin
		state_d = state_q;
		angle0_d = angle0_q;
		angle_d = angle_o;
		sat_d = sat_flag_o;
		angle_valid_d = 1'b0;
		unique case (state_q)
			S_IDLE: if (sample_valid_i) state_d = S_TRIM;
			S_TRIM: state_d = S_HYST;
			S_HYST: state_d = S_ATAN;
			S_ATAN: begin
				if (ctrl_q[CTRL_BYPASS]) begin
					angle0_d = unsigned'(sin_sel) + BYPASS_BIAS;
					state_d = S_OUT;
				end else begin
					state_d = S_WAIT;
				end
			end
			S_WAIT: begin
				if (cordic_done) begin
					angle0_d = cordic_angle;
					state_d = S_OUT;
				end
			end
			S_OUT: begin
				angle_d = ang_sum;
				// limits only flag, the angle itself passes untouched
				sat_d = ctrl_q[CTRL_THR_EN]
					&& (ang_sum[ANG_W-1 -: THR_W] < thr_low_q
					|| ang_sum[ANG_W-1 -: THR_W] > thr_high_q);
				angle_valid_d = 1'b1;
				state_d = S_IDLE;
			end
			default: state_d = S_IDLE;
		endcase
		busy_d = (state_d != S_IDLE);
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= S_IDLE;
			angle0_q <= '0;
			angle_o <= '0;
			sat_flag_o <= 1'b0;
			angle_valid_o <= 1'b0;
			busy_o <= 1'b0;
		end else if (ce_i) begin
			state_q <= state_d;
			angle0_q <= angle0_d;
			angle_o <= angle_d;
			sat_flag_o <= sat_d;
			angle_valid_o <= angle_valid_d;
			busy_o <= busy_d;
		end
	end

endmodule

// [tb/tap_src.sv]
// sample source standing in for the factory-corrected front end
module tap_src
	import tap_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// request from the bench
	input wire logic go_i,
	input wire logic [SAMPLE_W-1:0] a_i,
	input wire logic [SAMPLE_W-1:0] b_i,
	input wire logic [TEMP_W-1:0] t_i,
	// towards the block
	input wire logic busy_i,
	output logic valid_o,
	output logic [SAMPLE_W-1:0] a_o,
	output logic [SAMPLE_W-1:0] b_o,
	output logic [TEMP_W-1:0] t_o
);
	timeunit 1ns;
	timeprecision 100ps;
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			valid_o <= 1'b0;
			{a_o, b_o, t_o} <= '0;
		end else if (go_i) begin
			valid_o <= 1'b1;
			{a_o, b_o, t_o} <= {a_i, b_i, t_i};
		end else if (valid_o && !busy_i) begin
			// taken: lines flip so a late capture shows up
			valid_o <= 1'b0;
			{a_o, b_o, t_o} <= ~{a_o, b_o, t_o};
		end
	end
endmodule

// [tb/tap_trim_path_sva.sv]
// port assertions for the trim and angle path
module tap_chk (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// samples and angle
	input wire logic sample_valid_i,
	input wire logic busy_o,
	input wire logic angle_valid_o,
	input wire logic [15:0] angle_o,
	input wire logic sat_flag_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	chk_setup_answer: assert property (
		psel_i && !penable_i && ce_i |=> pready_o)
		else $error("no pready after setup");
	chk_ready_once: assert property (
		pready_o && ce_i |=> !pready_o)
		else $error("pready longer than one cycle");
	chk_err_ready: assert property (
		pslverr_o |-> pready_o && prdata_o == 32'h0)
		else $error("error without pready or with data");
	chk_take_busy: assert property (
		sample_valid_i && !busy_o && ce_i |=> busy_o)
		else $error("sample not taken while idle");
	chk_result_time: assert property (
		sample_valid_i && !busy_o && ce_i
		|=> !angle_valid_o [*4] ##[1:18] angle_valid_o)
		else $error("result latency out of range");
	chk_valid_pulse: assert property (
		angle_valid_o |=> !angle_valid_o)
		else $error("result strobe longer than one cycle");
	chk_valid_idle: assert property (
		angle_valid_o |-> !busy_o)
		else $error("result while still busy");
	chk_angle_hold: assert property (
		!angle_valid_o |-> $stable(angle_o) && $stable(sat_flag_o))
		else $error("angle changed without strobe");
	cover property (angle_valid_o && sat_flag_o);
	cover property (pslverr_o);
	cover property (sample_valid_i && busy_o);
endmodule

bind tap_trim_path tap_chk u_chk (.clock_i, .rstn_i, .ce_i, .psel_i,
	.penable_i, .prdata_o, .pready_o, .pslverr_o, .sample_valid_i,
	.busy_o, .angle_valid_o, .angle_o, .sat_flag_o);

// [tb/tap_trim_path_bench.sv]
// self-checking bench for the trim and angle path
module tap_trim_path_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o, rdat;
	logic pready_o, pslverr_o, rerr, busy_o, angle_valid_o, sat_flag_o;
	logic sample_valid_i, sat;
	logic go = 1'b0;
	logic ce = 1'b1;
	logic [15:0] sa = 16'h0000;
	logic [15:0] sb = 16'h0000;
	logic [11:0] st = 12'h800;
	logic [15:0] sample_a_i, sample_b_i, angle_o, ang;
	logic [11:0] temp_i;
	int fail_count = 0;
	int samples_checked = 0;

	tap_src u_src (.clock_i, .rstn_i, .go_i(go), .a_i(sa), .b_i(sb),
		.t_i(st), .busy_i(busy_o), .valid_o(sample_valid_i),
		.a_o(sample_a_i), .b_o(sample_b_i), .t_o(temp_i));
	tap_trim_path uut (.clock_i, .rstn_i, .ce_i(ce), .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .sample_valid_i, .sample_a_i,
		.sample_b_i, .temp_i, .busy_o, .angle_valid_o, .angle_o,
		.sat_flag_o);

	always #12.5 clock_i = ~clock_i;

	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] wd);
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= ad;
		pwdata_i <= wd;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clock_i);
		end while (pready_o !== 1'b1);
		rdat = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// waits for the strobe; only the watchdog ends a hang
	task automatic run(input logic [15:0] a, input logic [15:0] b,
		input logic [11:0] t);
		@(posedge clock_i);
		go <= 1'b1;
		sa <= a;
		sb <= b;
		st <= t;
		@(posedge clock_i);
		go <= 1'b0;
		do begin
			@(posedge clock_i);
		end while (angle_valid_o !== 1'b1);
		ang = angle_o;
		sat = sat_flag_o;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	// arctangent result allowed two codes either way
	task automatic near(input logic [15:0] e);
		logic [15:0] d;
		d = ang - e + 16'h0002;
		samples_checked++;
		if ($isunknown(ang) || d > 16'h0004) begin
			fail_count++;
			$display("unexpected angle: expected %h seen %h", e, ang);
		end
	endtask

	// first channel through bypass, e is the channel value
	task automatic by(input logic [15:0] a, input logic [11:0] t,
		input logic [15:0] e);
		run(a, 16'h0000, t);
		cmp("angle", {16'h0, e + 16'h8000}, {16'h0, ang});
	endtask

	task automatic t_regs();
		apb(1'b0, 8'h00, 32'h0);
		cmp("ctrl", 32'h0, rdat);
		apb(1'b0, 8'h20, 32'h0);
		cmp("gain a", 32'h800, rdat);
		apb(1'b0, 8'h40, 32'h0);
		cmp("gain b", 32'h800, rdat);
		apb(1'b1, 8'h1C, 32'hFF);
		cmp("slverr", 32'h1, {31'h0, rerr});
		$display("test regs done");
	endtask

	task automatic t_hyst();
		logic [15:0] o;
		apb(1'b1, 8'h00, 32'h4);
		apb(1'b1, 8'h34, 32'hA);
		by(16'h0064, 12'h800, 16'h0064);
		apb(1'b0, 8'h38, 32'h0);
		cmp("readback", 32'h64, {16'h0, rdat[15:0]});
		by(16'h006E, 12'h800, 16'h006E);
		by(16'h0078, 12'h800, 16'h0078);
		by(16'h0073, 12'h800, 16'h0078);
		by(16'h006F, 12'h800, 16'h0078);
		by(16'h0069, 12'h800, 16'h0069);
		o = 16'h805F;
		run(16'h005F, 16'h0000, 12'h800);
		cmp("hyst", {16'h0, o}, {16'h0, ang});
		run(16'h0062, 16'h0000, 12'h800);
		cmp("hyst", {16'h0, o}, {16'h0, ang});
		apb(1'b1, 8'h34, 32'h0);
		by(16'h0062, 12'h800, 16'h0062);
		// frozen enable must stretch the pipe, not corrupt it
		fork
			by(16'h0020, 12'h800, 16'h0020);
			begin
				repeat (4) @(posedge clock_i);
				ce <= 1'b0;
				repeat (5) @(posedge clock_i);
				cmp("frozen busy", 32'h1, {31'h0, busy_o});
				ce <= 1'b1;
			end
		join
		$display("test hyst done");
	endtask

	task automatic t_trim();
		logic [31:0] r [15][5];
		logic [31:0] d;
		r = '{'{8'h00, 32'h5, 12'h800, 16'h0064, 16'hFF9C},
			'{8'h00, 32'h6, 12'h800, 16'h0064, 16'h0064},
			'{8'h20, 32'h1000, 12'h800, 16'h0064, 16'h00C8},
			'{8'h20, 32'h0, 12'h800, 16'h0064, 16'h0000},
			'{8'h20, 32'h1000, 12'h800, 16'h7000, 16'h7FFF},
			'{8'h00, 32'h5, 12'h800, 16'h8000, 16'h7FFF},
			'{8'h24, 32'h2000000, 12'h880, 16'h0640, 16'h0672},
			'{8'h24, 32'h200, 12'h780, 16'h0640, 16'h05DC},
			'{8'h24, 32'h2000000, 12'h780, 16'h0640, 16'h0640},
			'{8'h28, 32'h1000000, 12'h880, 16'h0640, 16'h0643},
			'{8'h2C, 32'h5, 12'h800, 16'h0064, 16'h0078},
			'{8'h2C, 32'h2000, 12'h800, 16'h0000, 16'h8000},
			'{8'h30, 32'h80000, 12'h880, 16'h0064, 16'h0074},
			'{8'h30, 32'h10, 12'h780, 16'h0064, 16'h0054},
			'{8'h30, 32'h10, 12'h800, 16'h0064, 16'h0064}};
		foreach (r[i]) begin
			d = r[i][0] == 32'h0 ? 32'h4 : r[i][0] == 32'h20 ? 32'h800 : 32'h0;
			apb(1'b1, r[i][0][7:0], r[i][1]);
			by(r[i][3][15:0], r[i][2][11:0], r[i][4][15:0]);
			apb(1'b1, r[i][0][7:0], d);
		end
		$display("test trim done");
	endtask

	task automatic t_angle();
		logic [15:0] c [6][4];
		logic [16:0] s [4];
		c = '{'{16'h0000, 16'h0000, 16'h3E80, 16'h0000},
			'{16'h0000, 16'h3E80, 16'h0000, 16'h4000},
			'{16'h0000, 16'h0000, 16'hC180, 16'h8000},
			'{16'h0000, 16'hC180, 16'h0000, 16'hC000},
			'{16'h0008, 16'h3E80, 16'h0000, 16'h0000},
			'{16'h0008, 16'h0000, 16'h3E80, 16'h4000}};
		s = '{17'h09800, 17'h0A0FF, 17'h18F00, 17'h10000};
		foreach (c[i]) begin
			apb(1'b1, 8'h00, {16'h0, c[i][0]});
			run(c[i][1], c[i][2], 12'h800);
			near(c[i][3]);
		end
		apb(1'b1, 8'h00, 32'h4);
		apb(1'b1, 8'h04, 32'h1);
		by(16'h7FFF, 12'h800, 16'h8001);
		apb(1'b1, 8'h04, 32'h4000);
		by(16'hC000, 12'h800, 16'h4000);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h08, 32'h2010);
		apb(1'b1, 8'h00, 32'h14);
		foreach (s[i]) begin
			by(s[i][15:0], 12'h800, s[i][15:0]);
			cmp("sat", {31'h0, s[i][16]}, {31'h0, sat});
		end
		apb(1'b0, 8'h0C, 32'h0);
		cmp("angle reg", 32'h18000, {15'h0, rdat[16:0]});
		apb(1'b1, 8'h00, 32'h4);
		run(16'h0000, 16'h0000, 12'h800);
		cmp("sat", 32'h0, {31'h0, sat});
		apb(1'b1, 8'h10, 32'h4000);
		apb(1'b1, 8'h00, 32'hC);
		run(16'h03E8, 16'h0000, 12'h800);
		cmp("angle", 32'h81F4, {16'h0, ang});
		$display("test angle done");
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clock_i);
		rstn_i <= 1'b1;
		t_regs();
		t_hyst();
		t_trim();
		t_angle();
		close_out();
	end

	// about thirty times the expected run length
	initial begin
		repeat (20000) @(posedge clock_i);
		fail_count++;
		close_out();
	end
endmodule
